/* File: pwo_top.sv */
// pwm channel pair pin output stage with axi4-lite register access
// Overview of operation
// - ownership bit 0 hands pin to gpio logic, 1 to pwm
// - per-pin polarity bit; 1 makes the active level low
// - pair mode: 11 independent, 10 push-pull, 01 redundant, 00 complementary
// - override enable puts forced level on its pin instead of generator
// - active enabled fault drives both pins to trip levels
// - active enabled current limit drives both pins to limit levels
// - with write lock strap set, io register write needs unlock first
// - selected blank signal masks fault and limit per blank enables
// - blank source 0000 off, 0001-0110 channel 1-6 high, 1001 reserved
// - chop signal gates the high and/or low output when enabled
// - chop source 0000 internal chop clock, 0001-0011 channels 1-3
// - chop source 0100-0110 channels 4-6, 1001 reserved
// - gating enable 1 applies chop to its output, 0 removes it
`timescale 1ns/1ps
module pwo_top
  import pwo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [pwo_pkg::AW-1:0] s_axil_awaddr,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  output logic [1:0] s_axil_bresp,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  input wire logic [pwo_pkg::AW-1:0] s_axil_araddr,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  input wire logic write_lock_config,
  input wire logic modulator_enable,
  input wire logic period_start,
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic chop_clock,
  input wire logic [pwo_pkg::PEERS-1:0] peer_high,
  input wire logic trip_pin,
  input wire logic limit_pin,
  input wire logic trip_handling_mode,
  input wire logic limit_handling_mode,
  input wire logic high_blank_enable,
  input wire logic low_blank_enable,
  input wire logic gpio_high_o,
  input wire logic gpio_high_oe,
  input wire logic gpio_low_o,
  input wire logic gpio_low_oe,
  output logic high_side_output,
  output logic high_side_oe,
  output logic low_side_output,
  output logic low_side_oe,
  output logic trip_active,
  output logic limit_active
);
  pwo_reg_if rb ();

  pwo_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .awaddr(s_axil_awaddr),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .bresp(s_axil_bresp),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .araddr(s_axil_araddr),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rb(rb.bus)
  );

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] nw,
                                          input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  logic [DW-1:0] io_q;
  logic [DW-1:0] aux_q;
  pwo_key_t key_q;
  pwo_key_t key_d;
  logic lock_cfg_q;
  logic lock_seen_q;
  logic [SYNC_STAGES-1:0] trip_s_q;
  logic [SYNC_STAGES-1:0] limit_s_q;
  logic trip_f_q;
  logic limit_f_q;
  logic phase_q;
  logic [3:0] force_q;
  logic high_q;
  logic high_oe_q;
  logic low_q;
  logic low_oe_q;

  // register decode
  wire io_wr = rb.wr_en && rb.wr_addr == OFF_IO;
  wire aux_wr = rb.wr_en && rb.wr_addr == OFF_AUX;
  wire key_wr = rb.wr_en && rb.wr_addr == OFF_KEY;
  wire wr_mapped = rb.wr_addr == OFF_IO || rb.wr_addr == OFF_AUX ||
                   rb.wr_addr == OFF_KEY;
  wire io_locked = lock_cfg_q && key_q != PWO_KEY_OPEN;
  wire io_take = io_wr && !io_locked;
  assign rb.wr_err = !wr_mapped || (rb.wr_addr == OFF_IO && io_locked);

  // io register fields
  wire own_h = io_q[IO_OWN_H];
  wire own_l = io_q[IO_OWN_L];
  wire inv_h = io_q[IO_INV_H];
  wire inv_l = io_q[IO_INV_L];
  pwo_mode_t mode;
  assign mode = pwo_mode_t'(io_q[IO_MODE +: 2]);
  wire [1:0] trip_lv = io_q[IO_TRIP +: 2];
  wire [1:0] limit_lv = io_q[IO_LIMIT +: 2];
  wire swap = io_q[IO_SWAP];
  wire override_sync = io_q[IO_OVERRIDE_SYNC];
  wire [3:0] force_live = {io_q[IO_FEN_H], io_q[IO_FEN_L], io_q[IO_FORCE +: 2]};

  // auxiliary register fields
  wire [SRC_W-1:0] blank_code = aux_q[AUX_BLANK +: SRC_W];
  wire [SRC_W-1:0] gate_code = aux_q[AUX_GATE +: SRC_W];
  wire gate_en_h = aux_q[AUX_GEN_H];
  wire gate_en_l = aux_q[AUX_GEN_L];

  logic blank_sig;
  logic blank_hit;
  logic gate_sig;

  pwo_src_sel u_blank_sel (
    .code(blank_code),
    .peer(peer_high),
    .fallback(1'b0),
    .sel(blank_sig),
    .hit(blank_hit)
  );

  pwo_src_sel u_gate_sel (
    .code(gate_code),
    .peer(peer_high),
    .fallback(chop_clock),
    .sel(gate_sig),
    .hit()
  );

  // blanking only while a real source is chosen
  wire blank_act = blank_hit &&
                   ((blank_sig && high_blank_enable) ||
                    (!blank_sig && low_blank_enable));
  assign trip_active = trip_f_q && !blank_act && trip_handling_mode;
  assign limit_active = limit_f_q && !blank_act && limit_handling_mode;

  // pair mode; a disabled modulator drives both generator paths inactive; fault, limit and override still apply
  logic mode_h;
  logic mode_l;
  always_comb
  begin
    mode_h = 1'b0;
    mode_l = 1'b0;
    unique case (mode)
      PWO_MODE_COMP:
      begin
        mode_h = gen_high;
        mode_l = !gen_high;
      end
      PWO_MODE_REDUN:
      begin
        mode_h = gen_high;
        mode_l = gen_high;
      end
      PWO_MODE_PUSH:
      begin
        mode_h = gen_high && !phase_q;
        mode_l = gen_high && phase_q;
      end
      PWO_MODE_INDEP:
      begin
        mode_h = gen_high;
        mode_l = gen_low;
      end
    endcase
  end

  wire sw_h = modulator_enable && (swap ? mode_l : mode_h);
  wire sw_l = modulator_enable && (swap ? mode_h : mode_l);
  wire gated_h = sw_h && (!gate_en_h || gate_sig);
  wire gated_l = sw_l && (!gate_en_l || gate_sig);

  // fault outranks current limit, which outranks software override
  wire act_h = trip_active ? trip_lv[1] :
               limit_active ? limit_lv[1] :
               force_q[3] ? force_q[1] : gated_h;
  wire act_l = trip_active ? trip_lv[0] :
               limit_active ? limit_lv[0] :
               force_q[2] ? force_q[0] : gated_l;
  wire pin_h = act_h ^ inv_h;
  wire pin_l = act_l ^ inv_l;

  // read mux
  wire [DW-1:0] stat_word = {10'h000, key_q == PWO_KEY_OPEN, lock_cfg_q,
                             gate_sig, blank_act, limit_active, trip_active};
  assign rb.rd_err = !(rb.rd_addr == OFF_IO || rb.rd_addr == OFF_AUX ||
                       rb.rd_addr == OFF_KEY || rb.rd_addr == OFF_STAT);
  assign rb.rd_data = rb.rd_addr == OFF_IO ? io_q :
                      rb.rd_addr == OFF_AUX ? aux_q :
                      rb.rd_addr == OFF_STAT ? stat_word : 16'h0000;

  // unlock sequence: two key words in a row open one io register write
  always_comb
  begin
    key_d = key_q;
    if (key_wr)
    begin
      if (rb.wr_data == KEY_FIRST)
        key_d = PWO_KEY_HALF;
      else if (key_q == PWO_KEY_HALF && rb.wr_data == KEY_SECOND)
        key_d = PWO_KEY_OPEN;
      else
        key_d = PWO_KEY_IDLE;
    end
    else if (io_take)
      key_d = PWO_KEY_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_q <= IO_RST;
      aux_q <= AUX_RST;
      key_q <= PWO_KEY_IDLE;
    end
    else
    begin
      // pair mode is not frozen here; software keeps it still while running
      if (io_take)
        io_q <= merge(io_q, rb.wr_data, rb.wr_strb);
      if (aux_wr)
        aux_q <= merge(aux_q, rb.wr_data, rb.wr_strb) & AUX_MASK;
      key_q <= key_d;
    end
  end

  // the strap is taken once after reset; it is assumed static afterwards
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_cfg_q <= 1'b0;
      lock_seen_q <= 1'b0;
    end
    else if (!lock_seen_q)
    begin
      lock_cfg_q <= write_lock_config;
      lock_seen_q <= 1'b1;
    end
  end

  // pin inputs: a change counts once the last two stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trip_s_q <= '0;
      limit_s_q <= '0;
      trip_f_q <= 1'b0;
      limit_f_q <= 1'b0;
    end
    else
    begin
      trip_s_q <= {trip_s_q[1:0], trip_pin};
      limit_s_q <= {limit_s_q[1:0], limit_pin};
      if (trip_s_q[1] == trip_s_q[2])
        trip_f_q <= trip_s_q[2];
      if (limit_s_q[1] == limit_s_q[2])
        limit_f_q <= limit_s_q[2];
    end
  end

  // push-pull phase and optionally period-aligned override
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 1'b0;
      force_q <= '0;
    end
    else
    begin
      if (!modulator_enable)
        phase_q <= 1'b0;
      else if (period_start)
        phase_q <= !phase_q;
      if (!override_sync || period_start)
        force_q <= force_live;
    end
  end

  // pin ownership and registered pin drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_q <= 1'b0;
      high_oe_q <= 1'b0;
      low_q <= 1'b0;
      low_oe_q <= 1'b0;
    end
    else
    begin
      high_q <= own_h ? pin_h : gpio_high_o;
      high_oe_q <= own_h ? 1'b1 : gpio_high_oe;
      low_q <= own_l ? pin_l : gpio_low_o;
      low_oe_q <= own_l ? 1'b1 : gpio_low_oe;
    end
  end

  assign high_side_output = high_q;
  assign high_side_oe = high_oe_q;
  assign low_side_output = low_q;
  assign low_side_oe = low_oe_q;
endmodule : pwo_top

/* File: pwo_pkg.sv */
// constants, field positions and state types for the pwm pin output stage
package pwo_pkg;
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int PEERS = 6;
  localparam int SRC_W = 4;
  localparam logic [AW-1:0] OFF_IO = 4'h0;
  localparam logic [AW-1:0] OFF_AUX = 4'h4;
  localparam logic [AW-1:0] OFF_KEY = 4'h8;
  localparam logic [AW-1:0] OFF_STAT = 4'hC;
  localparam logic [DW-1:0] IO_RST = 16'hC000;
  localparam logic [DW-1:0] AUX_RST = 16'h0000;
  localparam logic [DW-1:0] AUX_MASK = 16'h0F3F;
  localparam logic [DW-1:0] KEY_FIRST = 16'hABCD;
  localparam logic [DW-1:0] KEY_SECOND = 16'h4321;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IO_OWN_H = 15;
  localparam int IO_OWN_L = 14;
  localparam int IO_INV_H = 13;
  localparam int IO_INV_L = 12;
  localparam int IO_MODE = 10;
  localparam int IO_FEN_H = 9;
  localparam int IO_FEN_L = 8;
  localparam int IO_FORCE = 6;
  localparam int IO_TRIP = 4;
  localparam int IO_LIMIT = 2;
  localparam int IO_SWAP = 1;
  localparam int IO_OVERRIDE_SYNC = 0;
  localparam int AUX_BLANK = 8;
  localparam int AUX_GATE = 2;
  localparam int AUX_GEN_H = 1;
  localparam int AUX_GEN_L = 0;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    PWO_MODE_COMP,
    PWO_MODE_REDUN,
    PWO_MODE_PUSH,
    PWO_MODE_INDEP
  } pwo_mode_t;
  typedef enum logic [1:0] {
    PWO_KEY_IDLE,
    PWO_KEY_HALF,
    PWO_KEY_OPEN
  } pwo_key_t;
endpackage : pwo_pkg

/* File: pwo_reg_if.sv */
// register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface pwo_reg_if;
  import pwo_pkg::*;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [1:0] wr_strb;
  logic wr_err;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : pwo_reg_if

/* File: pwo_axil.sv */
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module pwo_axil
  import pwo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  pwo_reg_if.bus rb
);
  logic aw_have_q;
  logic [AW-1:0] aw_addr_q;
  logic w_have_q;
  logic [DW-1:0] w_data_q;
  logic [1:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
  wire ar_take = arvalid & ~rvalid_q;

  assign awready = ~aw_have_q;
  assign wready = ~w_have_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rb.wr_en = do_wr;
  assign rb.wr_addr = {aw_addr_q[AW-1:2], 2'h0};
  assign rb.wr_data = w_data_q;
  assign rb.wr_strb = w_strb_q;
  assign rb.rd_addr = {araddr[AW-1:2], 2'h0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (do_wr)
        aw_have_q <= 1'b0;
      else if (awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (do_wr)
        w_have_q <= 1'b0;
      else if (wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= wdata[DW-1:0];
        w_strb_q <= wstrb[1:0];
      end
      if (do_wr)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= rb.wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rb.rd_err ? 32'h0000_0000 : {16'h0000, rb.rd_data};
      rresp_q <= rb.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end
endmodule : pwo_axil

/* File: pwo_src_sel.sv */
// picks one peer high-side output by a four-bit source code
`timescale 1ns/1ps
module pwo_src_sel
  import pwo_pkg::*;
(
  input wire logic [SRC_W-1:0] code,
  input wire logic [PEERS-1:0] peer,
  input wire logic fallback,
  output logic sel,
  output logic hit
);
  // codes 1..PEERS name a channel; zero and every reserved code fall back
  function automatic logic in_range(input logic [SRC_W-1:0] c);
    in_range = (c != 4'h0) && (c <= 4'(PEERS));
  endfunction : in_range

  wire [SRC_W-1:0] idx = code - 4'h1;
  assign hit = in_range(code);
  assign sel = hit ? peer[idx[2:0]] : fallback;
endmodule : pwo_src_sel

/* File: pwo_top_sva.sv */
// assertion checker for the pwm pin output stage
`timescale 1ns/1ps
module pwo_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic trip_pin,
  input wire logic limit_pin,
  input wire logic trip_handling_mode,
  input wire logic limit_handling_mode,
  input wire logic trip_active,
  input wire logic limit_active,
  input wire logic gpio_high_oe,
  input wire logic high_side_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  trip_enable_a: assert property (trip_active |-> trip_handling_mode)
    else $error("trip active with handling disabled");
  limit_enable_a: assert property (limit_active |-> limit_handling_mode)
    else $error("limit active with handling disabled");
  // three sync stages: four quiet samples clear the flag at the edge after the last
  trip_quiet_a: assert property (!trip_pin [*4] |=> !trip_active)
    else $error("trip active without trip input");
  limit_quiet_a: assert property (!limit_pin [*4] |=> !limit_active)
    else $error("limit active without limit input");
  high_owner_a: assert property (!high_side_oe && $past(aresetn) |-> !$past(gpio_high_oe))
    else $error("high pin released while port logic drives");
  read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped before rready");
  write_hold_a: assert property (s_axil_bvalid && !s_axil_bready
    |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped before bready");
  read_block_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("address accepted while read pending");
endmodule : pwo_top_sva
bind pwo_top pwo_top_sva i_sva (.aclk, .aresetn, .s_axil_arvalid, .s_axil_arready,
  .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_bvalid, .s_axil_bready,
  .s_axil_bresp, .trip_pin, .limit_pin, .trip_handling_mode, .limit_handling_mode,
  .trip_active, .limit_active, .gpio_high_oe, .high_side_oe);

/* File: pwo_pin_model.sv */
// power stage pads and port logic facing the pin output stage
`timescale 1ns/1ps
module pwo_pin_model (
  input wire logic gp_lvl,
  input wire logic gp_en,
  input wire logic high_side_output,
  input wire logic high_side_oe,
  input wire logic low_side_output,
  input wire logic low_side_oe,
  output logic gpio_high_o,
  output logic gpio_high_oe,
  output logic gpio_low_o,
  output logic gpio_low_oe,
  output logic pad_h,
  output logic pad_l
);
  // port logic drives opposite levels so a swapped pin shows
  assign gpio_high_o = gp_lvl;
  assign gpio_low_o = !gp_lvl;
  assign gpio_high_oe = gp_en;
  assign gpio_low_oe = gp_en;
  // released pads fall to the gate-drive pull-down
  assign pad_h = high_side_oe ? high_side_output : 1'b0;
  assign pad_l = low_side_oe ? low_side_output : 1'b0;
endmodule : pwo_pin_model

/* File: tb_pwm_output_pin_control.sv */
// self-checking bench for the pwm pin output stage
`timescale 1ns/1ps
module tb_pwm_output_pin_control;
  import pwo_pkg::*;
  logic aclk = 0, aresetn = 0, s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0, s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid, pad_h, pad_l, gp_lvl = 0, gp_en = 0;
  logic [AW-1:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic write_lock_config = 1, modulator_enable = 1, period_start = 0, gen_high = 0;
  logic gen_low = 0, chop_clock = 0, trip_pin = 0, limit_pin = 0, trip_handling_mode = 0;
  logic limit_handling_mode = 0, high_blank_enable = 0, low_blank_enable = 0;
  logic [PEERS-1:0] peer_high = 6'h00;
  logic gpio_high_o, gpio_high_oe, gpio_low_o, gpio_low_oe, high_side_output, high_side_oe;
  logic low_side_output, low_side_oe, trip_active, limit_active, sel;
  int fail_count = 0, n_tests = 0;
  pwo_top i_dut (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_awaddr,
    .s_axil_wvalid, .s_axil_wready, .s_axil_wdata, .s_axil_wstrb, .s_axil_bvalid,
    .s_axil_bready, .s_axil_bresp, .s_axil_arvalid, .s_axil_arready, .s_axil_araddr,
    .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_rresp, .write_lock_config,
    .modulator_enable, .period_start, .gen_high, .gen_low, .chop_clock, .peer_high,
    .trip_pin, .limit_pin, .trip_handling_mode, .limit_handling_mode, .high_blank_enable,
    .low_blank_enable, .gpio_high_o, .gpio_high_oe, .gpio_low_o, .gpio_low_oe,
    .high_side_output, .high_side_oe, .low_side_output, .low_side_oe, .trip_active,
    .limit_active);
  pwo_pin_model i_pins (.gp_lvl, .gp_en, .high_side_output, .high_side_oe, .low_side_output,
    .low_side_oe, .gpio_high_o, .gpio_high_oe, .gpio_low_o, .gpio_low_oe, .pad_h, .pad_l);
  task automatic summarize;
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    cmp(nm, {31'h0, exp}, {31'h0, got});
  endtask : cmp_bit
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= {16'h0000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    // bready comes late so the response has to stand while it waits
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (n == 3) s_axil_bready <= 1'b1;
    end while (!(s_axil_bvalid === 1'b1 && s_axil_bready) && n < 40);
    s_axil_bready <= 1'b0;
    cmp_bit("bvalid", 1'b1, s_axil_bvalid);
    cmp("bresp", {30'h0, er}, {30'h0, s_axil_bresp});
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [15:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    // rready comes late so the read data has to stand while it waits
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (n == 2) s_axil_rready <= 1'b1;
    end while (!(s_axil_rvalid === 1'b1 && s_axil_rready) && n < 40);
    s_axil_rready <= 1'b0;
    cmp_bit("rvalid", 1'b1, s_axil_rvalid);
    cmp("rdata", {16'h0000, exp}, s_axil_rdata);
    cmp("rresp", {30'h0, er}, {30'h0, s_axil_rresp});
  endtask : rd
  // pair mode is only rewritten with the modulator stopped
  task automatic io(input logic [15:0] d);
    modulator_enable <= 1'b0;
    wr(OFF_KEY, KEY_FIRST, RESP_OKAY);
    wr(OFF_KEY, KEY_SECOND, RESP_OKAY);
    wr(OFF_IO, d, RESP_OKAY);
    modulator_enable <= 1'b1;
  endtask : io
  // margin covers the input synchronisers plus the output register
  task automatic pins(input logic h, input logic l);
    repeat (6) @(posedge aclk);
    cmp_bit("pad_h", h, pad_h);
    cmp_bit("pad_l", l, pad_l);
  endtask : pins
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFF_IO, IO_RST, RESP_OKAY);
    rd(OFF_AUX, AUX_RST, RESP_OKAY);
    rd(OFF_KEY, 16'h0000, RESP_OKAY);
    wr(OFF_STAT, 16'hFFFF, RESP_SLVERR);
    wr(OFF_AUX, 16'hFFFF, RESP_OKAY);
    rd(OFF_AUX, AUX_MASK, RESP_OKAY);
    wr(OFF_IO, 16'hCC00, RESP_SLVERR);
    rd(OFF_IO, IO_RST, RESP_OKAY);
    wr(OFF_AUX, 16'h0000, RESP_OKAY);
    gen_high <= 1'b1;
    io(16'hCC00);
    pins(1'b1, 1'b0);
    io(16'hFC00);
    pins(1'b0, 1'b1);
    gen_high <= 1'b0;
    gp_en <= 1'b1;
    gp_lvl <= 1'b1;
    io(16'h0C00);
    pins(1'b1, 1'b0);
    gp_en <= 1'b0;
    pins(1'b0, 1'b0);
    cmp_bit("high_side_oe", 1'b0, high_side_oe);
    io(16'hCFE4);
    pins(1'b1, 1'b1);
    trip_pin <= 1'b1;
    limit_pin <= 1'b1;
    pins(1'b1, 1'b1);
    limit_handling_mode <= 1'b1;
    pins(1'b0, 1'b1);
    cmp_bit("limit_active", 1'b1, limit_active);
    trip_handling_mode <= 1'b1;
    pins(1'b1, 1'b0);
    high_blank_enable <= 1'b1;
    // a masked pair falls back to the forced levels
    for (int c = 0; c < 10; c++)
    begin
      sel = (c >= 1 && c <= 6);
      peer_high <= sel ? 6'(1 << (c - 1)) : 6'h3F;
      wr(OFF_AUX, {4'h0, c[3:0], 8'h00}, RESP_OKAY);
      pins(1'b1, sel);
      cmp_bit("trip_active", !sel, trip_active);
    end
    trip_pin <= 1'b0;
    limit_pin <= 1'b0;
    gen_high <= 1'b1;
    gen_low <= 1'b1;
    io(16'hCC00);
    for (int c = 0; c < 10; c++)
    begin
      sel = (c >= 1 && c <= 6);
      peer_high <= sel ? 6'(1 << (c - 1)) : 6'h00;
      wr(OFF_AUX, {10'h000, c[3:0], 2'b10}, RESP_OKAY);
      pins(sel, 1'b1);
    end
    wr(OFF_AUX, 16'h0003, RESP_OKAY);
    chop_clock <= 1'b1;
    pins(1'b1, 1'b1);
    chop_clock <= 1'b0;
    pins(1'b0, 1'b0);
    wr(OFF_AUX, 16'h0000, RESP_OKAY);
    pins(1'b1, 1'b1);
    io(16'hC000);
    pins(1'b1, 1'b0);
    io(16'hC400);
    pins(1'b1, 1'b1);
    io(16'hC800);
    pins(1'b1, 1'b0);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
    pins(1'b0, 1'b1);
    gen_low <= 1'b0;
    io(16'hCC02);
    pins(1'b0, 1'b1);
    // a period-aligned override waits for the next period start
    io(16'hCF41);
    pins(1'b1, 1'b0);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
    pins(1'b0, 1'b1);
    summarize();
  end
endmodule : tb_pwm_output_pin_control
